// ### design/home_seek_push_sequencer.sv
// Push-motion end handling and return-to-home sequencing with an APB register file
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`include "hsp_defs.svh"
module home_seek_push_sequencer import hsp_pkg::*; #(
	parameter int CLK_HZ = `CLK_HZ
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Host control pins
	input  wire logic        op_select_bit0,
	input  wire logic [4:1]  op_select_mid,
	input  wire logic        op_select_bit5,
	input  wire logic        start_in,
	input  wire logic        home_in,
	input  wire logic        preset_cmd,
	output logic             ready_out,
	output logic             push_status_out,
	output logic             home_done_out,
	// Sensors
	input  wire logic        home_sensor,
	input  wire logic        limit_sensor,
	input  wire logic        sensor_in_a,
	input  wire logic        phase_timing_signal,
	input  wire logic        push_contact,
	// Motor drive
	output logic             step_out,
	output logic             dir_out,
	output logic [9:0]       current_out,
	output logic [19:0]      accel_out
);
	seq_state_e        state_q, state_d;
	home_cfg_s         cfg_q;
	logic [19:0]       run_spd_q, start_spd_q, accel_q, op_spd_q;
	logic [23:0]       home_ofs_q, preset_q, push_dist_q, cmd_pos_q;
	logic [9:0]        push_cur_q;
	logic              ready_q, push_q, hdone_q, home_prev_q, lim_prev_q;
	logic [5:0]        sel_q;
	logic              seek_dir_q, seek_dir_d;
	move_cmd_s         mv_d;
	logic              mv_load;
	logic              sg_step, sg_dir, sg_busy, sg_done;

	// Register decode
	wire        wr_en = psel && penable && pwrite;
	wire [5:0]  sel_in = {op_select_bit5, op_select_mid, op_select_bit0};
	wire        hit_ctrl = (paddr == `OFS_CTRL);
	wire        mapped = hit_ctrl || paddr == `OFS_RUN_SPD || paddr == `OFS_START_SPD
		|| paddr == `OFS_ACCEL || paddr == `OFS_HOME_OFS || paddr == `OFS_PUSH_CUR
		|| paddr == `OFS_PRESET || paddr == `OFS_PUSH_DIST || paddr == `OFS_OP_SPD
		|| paddr == `OFS_STATUS || paddr == `OFS_CMD_POS;
	wire        idle = (state_q == S_IDLE);
	wire        take_op = idle && ready_q && start_in;
	wire        take_home = idle && ready_q && home_in && !start_in;
	wire        take_preset = idle && ready_q && preset_cmd && !start_in && !home_in;
	wire        home_rise = home_sensor && !home_prev_q;
	wire        lim_rise = limit_sensor && !lim_prev_q;
	wire        refine_en = cfg_q.sensor_in_a_en || cfg_q.tim_en;
	// Both enabled signals must agree while the home sensor is still active
	wire        refine_hit = home_sensor && (!cfg_q.sensor_in_a_en || sensor_in_a)
		&& (!cfg_q.tim_en || phase_timing_signal);
	wire [19:0] final_spd = (start_spd_q < `FINAL_SPD_CAP) ? start_spd_q
		: `FINAL_SPD_CAP;
	wire        ofs_neg = home_ofs_q[23];
	wire [23:0] ofs_mag = ofs_neg ? 24'h000000 - home_ofs_q : home_ofs_q;
	wire [19:0] seek_spd = (cfg_q.mode == `MODE_3SENSOR) ? run_spd_q : start_spd_q;

	// Reads are side-effect free; status shows the live sequencer state
	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		case (a)
			`OFS_CTRL:      rd_mux = {27'h0, cfg_q.tim_en, cfg_q.sensor_in_a_en, cfg_q.dir, cfg_q.mode};
			`OFS_RUN_SPD:   rd_mux = {12'h0, run_spd_q};
			`OFS_START_SPD: rd_mux = {12'h0, start_spd_q};
			`OFS_ACCEL:     rd_mux = {12'h0, accel_q};
			`OFS_HOME_OFS:  rd_mux = {{8{home_ofs_q[23]}}, home_ofs_q};
			`OFS_PUSH_CUR:  rd_mux = {22'h0, push_cur_q};
			`OFS_PRESET:    rd_mux = {{8{preset_q[23]}}, preset_q};
			`OFS_PUSH_DIST: rd_mux = {8'h0, push_dist_q};
			`OFS_OP_SPD:    rd_mux = {12'h0, op_spd_q};
			`OFS_STATUS:    rd_mux = {16'h0, 2'h0, sel_q, 4'(state_q), sg_busy,
				hdone_q, push_q, ready_q};
			`OFS_CMD_POS:   rd_mux = {{8{cmd_pos_q[23]}}, cmd_pos_q};
			default:        rd_mux = 32'h00000000;
		endcase
	endfunction

	// Zero-wait slave, unmapped addresses answer with an error and read zero
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = (psel && !pwrite) ? rd_mux(paddr) : 32'h00000000;

	// Configuration registers; widths bound the documented ranges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= '{mode: `RST_MODE, dir: `RST_DIR, sensor_in_a_en: 1'b0, tim_en: 1'b0};
			run_spd_q <= `RST_RUN_SPD;
			start_spd_q <= `RST_START_SPD;
			accel_q <= `RST_ACCEL;
			home_ofs_q <= `RST_HOME_OFS;
			push_cur_q <= `RST_PUSH_CUR;
			preset_q <= `RST_PRESET;
			push_dist_q <= `RST_PUSH_DIST;
			op_spd_q <= `RST_OP_SPD;
		end else if (wr_en) begin
			case (paddr)
				`OFS_CTRL: begin
					cfg_q.mode <= (pwdata[1:0] == 2'h3) ? cfg_q.mode : pwdata[1:0];
					cfg_q.dir <= pwdata[`CTRL_DIR_BIT];
					cfg_q.sensor_in_a_en <= pwdata[`CTRL_SENSOR_IN_A_BIT];
					cfg_q.tim_en <= pwdata[`CTRL_TIM_BIT];
				end
				`OFS_RUN_SPD:   run_spd_q <= pwdata[19:0];
				`OFS_START_SPD: start_spd_q <= pwdata[19:0];
				`OFS_ACCEL:     accel_q <= pwdata[19:0];
				`OFS_HOME_OFS:  home_ofs_q <= pwdata[23:0];
				`OFS_PUSH_CUR:  push_cur_q <= pwdata[9:0];
				`OFS_PRESET:    preset_q <= pwdata[23:0];
				`OFS_PUSH_DIST: push_dist_q <= pwdata[23:0];
				`OFS_OP_SPD:    op_spd_q <= pwdata[19:0];
				default: ;
			endcase
		end
	end

	// Sequencer next state and move requests
	always_comb begin
		state_d = state_q;
		seek_dir_d = seek_dir_q;
		mv_load = 1'b0;
		mv_d = '{count: 24'h0, speed: seek_spd, dir: seek_dir_q};
		case (state_q)
			S_IDLE: begin
				if (take_op) begin
					state_d = S_OP_RUN;
					mv_load = 1'b1;
					mv_d = '{count: push_dist_q, speed: op_spd_q, dir: 1'b1};
				end else if (take_home) begin
					state_d = S_SEEK;
					seek_dir_d = cfg_q.dir;
					mv_load = 1'b1;
					mv_d = '{count: 24'h0, speed: seek_spd, dir: cfg_q.dir};
				end
			end
			S_OP_RUN: begin
				if (push_contact) begin
					state_d = S_PUSH_ACK;
				end else if (sg_done) begin
					state_d = S_IDLE;
				end
			end
			S_PUSH_ACK: state_d = S_IDLE;
			S_SEEK: begin
				case (cfg_q.mode)
					`MODE_3SENSOR: begin
						if (home_rise) begin
							state_d = refine_en ? S_REFINE : S_OFFSET;
							mv_load = refine_en;
							mv_d = '{count: 24'h0, speed: final_spd, dir: seek_dir_q};
						end else if (lim_rise) begin
							seek_dir_d = !seek_dir_q;
							mv_load = 1'b1;
							mv_d = '{count: 24'h0, speed: seek_spd, dir: !seek_dir_q};
						end
					end
					`MODE_2SENSOR: begin
						if (limit_sensor) begin
							state_d = S_ESCAPE;
							seek_dir_d = !seek_dir_q;
							mv_load = 1'b1;
							mv_d = '{count: 24'h0, speed: final_spd, dir: !seek_dir_q};
						end
					end
					default: begin
						if (push_contact) begin
							state_d = S_RETREAT;
							seek_dir_d = !seek_dir_q;
							mv_load = 1'b1;
							mv_d = '{count: `RETREAT_STEPS, speed: final_spd, dir: !seek_dir_q};
						end
					end
				endcase
			end
			S_ESCAPE: begin
				if (!limit_sensor) begin
					state_d = S_RETREAT;
					mv_load = 1'b1;
					mv_d = '{count: `RETREAT_STEPS, speed: final_spd, dir: seek_dir_q};
				end
			end
			S_RETREAT: if (sg_done) state_d = S_OFFSET;
			S_REFINE: if (refine_hit) state_d = S_OFFSET;
			S_OFFSET: begin
				if (ofs_mag != 24'h0) begin
					state_d = S_DONE;
					mv_load = 1'b1;
					mv_d = '{count: ofs_mag, speed: run_spd_q, dir: !ofs_neg};
				end else begin
					state_d = S_DONE;
				end
			end
			S_DONE: if (!sg_busy) state_d = S_IDLE;
			default: state_d = S_IDLE;
		endcase
	end

	// Any leftover continuous move stops when a sensor ends its phase
	wire halt = !mv_load && sg_busy
		&& ((state_q == S_OP_RUN && push_contact) || state_d == S_OFFSET);

	step_gen #(
		.CLK_HZ (CLK_HZ)
	) u_step (
		.pclk     (pclk),
		.presetn  (presetn),
		.load     (mv_load),
		.cmd      (mv_d),
		.halt     (halt),
		.step_out (sg_step),
		.dir_out  (sg_dir),
		.busy     (sg_busy),
		.done     (sg_done)
	);

	// Sequencer state, host handshake outputs and command position
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= S_IDLE;
			seek_dir_q <= 1'b1;
			ready_q <= 1'b0;
			push_q <= 1'b0;
			hdone_q <= 1'b0;
			sel_q <= 6'h00;
			cmd_pos_q <= 24'h000000;
			home_prev_q <= 1'b0;
			lim_prev_q <= 1'b0;
		end else begin
			state_q <= state_d;
			seek_dir_q <= seek_dir_d;
			home_prev_q <= home_sensor;
			lim_prev_q <= limit_sensor;
			// Ready rises one cycle after push status, never with it
			ready_q <= (state_d == S_IDLE) && (state_q != S_OP_RUN || !push_contact);
			if (take_op || take_home) begin
				push_q <= 1'b0;
				hdone_q <= 1'b0;
			end
			if (take_op) sel_q <= sel_in;
			if (state_q == S_OP_RUN && push_contact) push_q <= 1'b1;
			if (state_q == S_DONE && !sg_busy) begin
				hdone_q <= 1'b1;
				cmd_pos_q <= 24'h000000;
			end else if (take_preset) begin
				cmd_pos_q <= preset_q;
			end else if (sg_step) begin
				cmd_pos_q <= sg_dir ? cmd_pos_q + 24'h000001 : cmd_pos_q - 24'h000001;
			end
		end
	end

	assign ready_out = ready_q;
	assign push_status_out = push_q;
	assign home_done_out = hdone_q;
	assign step_out = sg_step;
	assign dir_out = sg_dir;
	// Push current only applies while a push or push homing is running
	assign current_out = (state_q == S_OP_RUN || state_q == S_PUSH_ACK
		|| (cfg_q.mode == `MODE_PUSH && !idle)) ? push_cur_q : `RST_PUSH_CUR;
	assign accel_out = accel_q;

	// Steps issued while retreating, so the fixed count is checked at the motor side
	logic [8:0] retreat_cnt_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			retreat_cnt_q <= 9'h000;
		end else if (mv_load) begin
			retreat_cnt_q <= 9'h000;
		end else if (state_q == S_RETREAT && sg_step) begin
			retreat_cnt_q <= retreat_cnt_q + 9'h001;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	push_order_a: assert property ($rose(push_q) |-> !ready_q ##1 ready_q)
		else $error("push status did not lead ready by one cycle");
	push_miss_a: assert property (state_q == S_OP_RUN && sg_done && !push_contact
		|=> ready_q && !push_q) else $error("missed push did not end cleanly");
	start_take_a: assert property (take_op |=> !ready_q [*2])
		else $error("ready stayed high after start");
	busy_ready_a: assert property (state_q != S_IDLE |-> !ready_q)
		else $error("ready high during operation");
	home_zero_a: assert property ($rose(hdone_q) |-> cmd_pos_q == 24'h000000)
		else $error("home done with nonzero position");
	retreat_cnt_a: assert property (state_d == S_RETREAT && mv_load
		|-> mv_d.count == `RETREAT_STEPS) else $error("retreat not 200 steps");
	seek_speed_a: assert property (take_home && cfg_q.mode == `MODE_3SENSOR
		|-> mv_d.speed == run_spd_q) else $error("3-sensor seek speed wrong");
	final_spd_a: assert property (state_d == S_ESCAPE && mv_load
		|-> mv_d.speed <= `FINAL_SPD_CAP && mv_d.speed <= start_spd_q)
		else $error("final approach speed wrong");
	preset_load_a: assert property (take_preset |=> cmd_pos_q == $past(preset_q))
		else $error("preset not loaded");
	reverse_dir_a: assert property (state_q == S_SEEK
		&& (state_d == S_ESCAPE || state_d == S_RETREAT) |=> dir_out != $past(dir_out))
		else $error("homing did not reverse");
	retreat_len_a: assert property (state_q == S_RETREAT && sg_done
		|-> sg_step && 24'(retreat_cnt_q) == `RETREAT_STEPS - 24'h000001)
		else $error("retreat step count wrong");
	done_ready_a: assert property ($rose(hdone_q) |-> ready_q && !sg_busy)
		else $error("home done without ready or with motor running");

	push_hit_c: cover property ($rose(push_q));
	home_done_c: cover property ($rose(hdone_q) && cfg_q.mode == `MODE_2SENSOR);
	refine_c: cover property (state_q == S_REFINE ##1 state_q == S_OFFSET);
	escape_c: cover property (state_q == S_ESCAPE ##1 state_q == S_RETREAT);
endmodule

// ### design/hsp_defs.svh
// Offsets, field positions, reset values and counts of the home-seek and push sequencer
`ifndef HSP_DEFS_SVH
`define HSP_DEFS_SVH
`define CLK_HZ          10000000
`define POS_W           24
`define SPD_W           20
`define ADDR_W          8
`define OFS_CTRL        8'h00
`define OFS_RUN_SPD     8'h04
`define OFS_START_SPD   8'h08
`define OFS_ACCEL       8'h0c
`define OFS_HOME_OFS    8'h10
`define OFS_PUSH_CUR    8'h14
`define OFS_PRESET      8'h18
`define OFS_PUSH_DIST   8'h1c
`define OFS_OP_SPD      8'h20
`define OFS_STATUS      8'h24
`define OFS_CMD_POS     8'h28
`define CTRL_MODE_LSB   0
`define CTRL_DIR_BIT    2
`define CTRL_SENSOR_IN_A_BIT   3
`define CTRL_TIM_BIT    4
`define MODE_2SENSOR    2'h0
`define MODE_3SENSOR    2'h1
`define MODE_PUSH       2'h2
`define RST_MODE        2'h1
`define RST_DIR         1'b1
`define RST_RUN_SPD     20'h003e8
`define RST_START_SPD   20'h001f4
`define RST_ACCEL       20'h003e8
`define RST_HOME_OFS    24'h000000
`define RST_PUSH_CUR    10'h3e8
`define RST_PRESET      24'h000000
`define RST_PUSH_DIST   24'h001388
`define RST_OP_SPD      20'h001f4
`define FINAL_SPD_CAP   20'h001f4
`define RETREAT_STEPS   24'h0000c8
`endif

// ### design/hsp_pkg.sv
// Types shared by the sequencer and its step generator
package hsp_pkg;
	typedef enum {
		S_IDLE, S_OP_RUN, S_PUSH_ACK, S_SEEK, S_ESCAPE, S_RETREAT, S_REFINE,
		S_OFFSET, S_DONE
	} seq_state_e;

	// One move request to the step generator; count zero runs until reloaded or halted
	typedef struct packed {
		logic [23:0] count;
		logic [19:0] speed;
		logic        dir;
	} move_cmd_s;

	typedef struct packed {
		logic [1:0] mode;
		logic       dir;
		logic       sensor_in_a_en;
		logic       tim_en;
	} home_cfg_s;
endpackage

// ### design/step_gen.sv
// Step pulse generator with a phase accumulator and a step down-counter
`timescale 1ns/1ns
`include "hsp_defs.svh"
module step_gen import hsp_pkg::*; #(
	parameter int CLK_HZ = `CLK_HZ
) (
	// Clock and reset
	input  wire logic      pclk,
	input  wire logic      presetn,
	// Move request
	input  wire logic      load,
	input  wire move_cmd_s cmd,
	input  wire logic      halt,
	// Motor side
	output logic           step_out,
	output logic           dir_out,
	output logic           busy,
	output logic           done
);
	localparam logic [24:0] LIMIT = 25'(CLK_HZ);

	logic [24:0] acc_q, acc_d;
	logic [23:0] left_q, left_d;
	logic        run_q, run_d, cont_q, cont_d, dir_q, dir_d, step_d, done_d;
	logic [19:0] spd_q, spd_d;
	logic        step_q, done_q;
	wire  [24:0] sum = acc_q + 25'(spd_q);
	wire         tick = run_q && (sum >= LIMIT);

	// Next move state; a load restarts at once so speed changes need no gap
	always_comb begin
		acc_d = acc_q;
		left_d = left_q;
		run_d = run_q;
		cont_d = cont_q;
		dir_d = dir_q;
		spd_d = spd_q;
		step_d = 1'b0;
		done_d = 1'b0;
		if (load) begin
			acc_d = '0;
			left_d = cmd.count;
			cont_d = (cmd.count == '0);
			run_d = 1'b1;
			dir_d = cmd.dir;
			spd_d = cmd.speed;
		end else if (halt && run_q) begin
			run_d = 1'b0;
			done_d = 1'b1;
		end else if (run_q) begin
			acc_d = tick ? sum - LIMIT : sum;
			step_d = tick;
			if (tick && !cont_q) begin
				left_d = left_q - 24'h000001;
				if (left_q == 24'h000001) begin
					run_d = 1'b0;
					done_d = 1'b1;
				end
			end
		end
	end

	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q <= '0;
			left_q <= '0;
			run_q <= 1'b0;
			cont_q <= 1'b0;
			dir_q <= 1'b0;
			spd_q <= '0;
			step_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			left_q <= left_d;
			run_q <= run_d;
			cont_q <= cont_d;
			dir_q <= dir_d;
			spd_q <= spd_d;
			step_q <= step_d;
			done_q <= done_d;
		end
	end

	assign step_out = step_q;
	assign dir_out = dir_q;
	assign busy = run_q;
	assign done = done_q;
endmodule

// ### test/host_model.sv
// Host controller model driving the select, start, home and preset pins
`timescale 1ns/1ns
module host_model (
	// Clock and status
	input  wire logic pclk,
	input  wire logic ready_out,
	// Control pins
	output logic [5:0] sel,
	output logic       start_in,
	output logic       home_in,
	output logic       preset_cmd
);
	// Quiet pins from time zero
	initial begin
		sel = 6'h00;
		{start_in, home_in, preset_cmd} = 3'h0;
	end

	// Kind 0 start, 1 home, 2 preset; same puts select and request on one edge
	task automatic request(input logic [1:0] kind, input logic [5:0] s, input bit same,
		input int lag);
		while (ready_out !== 1'b1) @(negedge pclk);
		@(posedge pclk);
		if (!same) begin
			sel <= s;
			@(posedge pclk);
		end
		sel <= s;
		start_in <= (kind == 2'h0);
		home_in <= (kind == 2'h1);
		preset_cmd <= (kind == 2'h2);
		// Start and home release only once ready is seen low, preset after one edge; lag models a slow host
		if (kind != 2'h2) begin
			do @(negedge pclk); while (ready_out !== 1'b0);
			repeat (lag) @(posedge pclk);
		end
		@(posedge pclk);
		{start_in, home_in, preset_cmd} <= 3'h0;
	endtask
endmodule

// ### test/home_seek_push_sequencer_test.sv
// Self-checking bench for the home-seek and push sequencer
`timescale 1ns/1ns
module home_seek_push_sequencer_test;
	import hsp_pkg::*;
	// Short clock rate keeps step periods to tens of cycles
	localparam int CLK = 10000;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [5:0]  sel;
	logic        start_in, home_in, preset_cmd, ready_out, push_status_out, home_done_out;
	logic        home_sensor, limit_sensor, sensor_in_a, phase_timing_signal, push_contact;
	logic        step_out, dir_out;
	logic [9:0]  current_out;
	logic [19:0] accel_out;
	int          num_errors, comparisons, cycles, steps;

	home_seek_push_sequencer #(.CLK_HZ(CLK)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .op_select_bit0(sel[0]),
		.op_select_mid(sel[4:1]), .op_select_bit5(sel[5]), .start_in(start_in),
		.home_in(home_in), .preset_cmd(preset_cmd), .ready_out(ready_out),
		.push_status_out(push_status_out), .home_done_out(home_done_out),
		.home_sensor(home_sensor), .limit_sensor(limit_sensor), .sensor_in_a(sensor_in_a),
		.phase_timing_signal(phase_timing_signal), .push_contact(push_contact),
		.step_out(step_out), .dir_out(dir_out), .current_out(current_out),
		.accel_out(accel_out));
	host_model host (.pclk(pclk), .ready_out(ready_out), .sel(sel), .start_in(start_in),
		.home_in(home_in), .preset_cmd(preset_cmd));

	// Clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// Step tally and hang guard
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (step_out === 1'b1) steps <= steps + 1;
		if (cycles == 40000) begin
			num_errors++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp);
	endtask
	// Cycles between two step pulses; ends just after a step
	task automatic gap(output int g);
		while (step_out !== 1'b1) @(negedge pclk);
		g = 0;
		do begin
			@(negedge pclk);
			g++;
		end while (step_out !== 1'b1);
	endtask
	// Ready must not come back before homing is done
	task automatic wait_home();
		logic early;
		early = 1'b0;
		while (home_done_out !== 1'b1) begin
			if (ready_out === 1'b1) early = 1'b1;
			@(negedge pclk);
		end
		chk(32'(early), 32'h0);
		chk(32'(ready_out), 32'h1);
	endtask

	task automatic t_regs();
		logic [31:0] r;
		logic        e;
		rd_chk(8'h00, 32'h5);
		rd_chk(8'h04, 32'h3e8);
		rd_chk(8'h08, 32'h1f4);
		rd_chk(8'h0c, 32'h3e8);
		rd_chk(8'h10, 32'h0);
		rd_chk(8'h14, 32'h3e8);
		rd_chk(8'h18, 32'h0);
		apb(1'b0, 8'h3c, 32'h0, r, e);
		chk(32'(e), 32'h1);
		wr(8'h00, 32'h7);
		rd_chk(8'h00, 32'h5);
		chk(32'(current_out), 32'h3e8);
		chk(32'(accel_out), 32'h3e8);
		$display("test regs done");
	endtask
	task automatic t_push_contact();
		int g;
		wr(8'h1c, 32'd20);
		wr(8'h20, 32'h3e8);
		wr(8'h14, 32'h1f4);
		host.request(2'h0, 6'h01, 1'b0, 0);
		chk(32'(current_out), 32'h1f4);
		gap(g);
		@(posedge pclk);
		push_contact <= 1'b1;
		while (push_status_out !== 1'b1) @(negedge pclk);
		chk(32'(ready_out), 32'h0);
		@(negedge pclk);
		chk(32'(ready_out), 32'h1);
		@(posedge pclk);
		push_contact <= 1'b0;
		$display("test push contact done");
	endtask
	task automatic t_push_free();
		int base;
		base = steps;
		host.request(2'h0, 6'h2a, 1'b1, 3);
		while (ready_out !== 1'b1) @(negedge pclk);
		chk(32'(push_status_out), 32'h0);
		chk(32'(steps - base), 32'd20);
		rd_chk(8'h24, 32'h2a01);
		$display("test push free done");
	endtask
	task automatic t_home3(input logic [1:0] rf);
		int g;
		int base;
		wr(8'h10, (rf == 2'h0) ? 32'h5 : 32'h0);
		wr(8'h00, 32'h5 | (32'(rf) << 3));
		host.request(2'h1, 6'h00, 1'b0, 2);
		gap(g);
		chk(32'(g), 32'd10);
		@(posedge pclk);
		home_sensor <= 1'b1;
		@(negedge pclk);
		base = steps;
		// Refinement holds off completion until sensor_in_a (bit 0) or phase timing (bit 1)
		if (rf != 2'h0) begin
			repeat (30) @(negedge pclk);
			chk(32'(home_done_out), 32'h0);
			@(posedge pclk);
			// Phase timing given as a level; host keeps resolution a multiple of 50
			{phase_timing_signal, sensor_in_a} <= rf;
		end
		wait_home();
		// Refinement creeps at 500 Hz: one step in its 31 cycles; else the 5-step offset
		chk(32'(steps - base), (rf == 2'h0) ? 32'h5 : 32'h1);
		rd_chk(8'h28, 32'h0);
		{home_sensor, sensor_in_a, phase_timing_signal} <= 3'h0;
		$display("test home three sensor done");
	endtask
	task automatic t_home2();
		int g;
		int base;
		wr(8'h00, 32'h4);
		wr(8'h08, 32'd250);
		host.request(2'h1, 6'h00, 1'b0, 0);
		gap(g);
		chk(32'(g), 32'd40);
		chk(32'(dir_out), 32'h1);
		@(posedge pclk);
		limit_sensor <= 1'b1;
		while (dir_out !== 1'b0) @(negedge pclk);
		gap(g);
		chk(32'(g), 32'd40);
		@(posedge pclk);
		limit_sensor <= 1'b0;
		@(negedge pclk);
		base = steps;
		wait_home();
		chk(32'(steps - base), 32'd200);
		$display("test home two sensor done");
	endtask
	task automatic t_home_push();
		int g;
		int base;
		wr(8'h00, 32'h6);
		wr(8'h08, 32'h3e8);
		host.request(2'h1, 6'h00, 1'b0, 0);
		gap(g);
		chk(32'(g), 32'd10);
		chk(32'(current_out), 32'h1f4);
		@(posedge pclk);
		push_contact <= 1'b1;
		@(negedge pclk);
		base = steps;
		while (dir_out !== 1'b0) @(negedge pclk);
		@(posedge pclk);
		push_contact <= 1'b0;
		// Retreat runs at the capped final speed, 500 Hz from a 1000 Hz start
		gap(g);
		chk(32'(g), 32'd20);
		wait_home();
		chk(32'(steps - base), 32'd200);
		rd_chk(8'h28, 32'h0);
		$display("test home push done");
	endtask
	task automatic t_preset();
		wr(8'h18, 32'hfffff0);
		host.request(2'h2, 6'h00, 1'b0, 0);
		repeat (2) @(negedge pclk);
		chk(32'(ready_out), 32'h1);
		rd_chk(8'h28, 32'hfffffff0);
		$display("test preset done");
	endtask

	// Reset, then the scenarios in turn
	initial begin
		{num_errors, comparisons, cycles, steps} = '0;
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{home_sensor, limit_sensor, sensor_in_a, phase_timing_signal, push_contact} = 5'h00;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		t_regs();
		t_push_contact();
		t_push_free();
		t_home3(2'h0);
		t_home3(2'h1);
		t_home3(2'h2);
		t_home2();
		t_home_push();
		t_preset();
		finish_test();
	end
endmodule
